//--- core/otp_defs.svh
// Register offsets, field positions, reset values and timing counts of the clock control block.
// Operation
// [R1] Trim register bit 7 always reads zero.
// [R2] Trim bits 6:0 set oscillator frequency.
// [R3] Reset loads factory calibration byte into trim.
// [R4] Software changes trim by at most 0x20.
// [R5] Trim not above plus ten percent during writes.
// [R6] Prescale bits 6:4 always read zero.
// [R7] Change enable sets only with others zero.
// [R8] Change enable clears after four cycles or write.
// [R9] Rewriting change enable neither extends nor clears.
// [R10] Division written only inside the enable window.
// [R11] Software disables interrupts during the sequence.
// [R12] Reset division is eight with fuse, else one.
// [R13] Protected write accepts any division, fuse ignored.
// [R14] Code n divides by two to n.
// [R15] Divided clock enable drives CPU and peripherals.
// [R16] Software picks division within allowed frequency.
// [R17] Division change produces no short clock period.
// [R18] New rate active within old plus two new.
// [R19] Reserved division code leaves division unchanged.
// [R20] Calibration byte and fuse sampled during reset.
`ifndef OTP_DEFS_SVH
`define OTP_DEFS_SVH
`define OTP_ADDR_PRESCALE 8'h26
`define OTP_ADDR_TRIM 8'h31
`define OTP_PRESCALE_CE_BIT 7
`define OTP_TRIM_RESERVED_BIT 7
`define OTP_DIV_RESET_FUSED 4'h3
`define OTP_DIV_RESET_PLAIN 4'h0
`define OTP_DIV_MAX_CODE 4'h8
`define OTP_CE_WINDOW_CYCLES 3'h4
`endif

//--- core/otp_pkg.sv
// Types shared by the clock control block.
package otp_pkg;
    typedef logic [7:0] otp_byte_t;
    typedef logic [3:0] otp_div_t;
    typedef logic [6:0] otp_trim_t;
    typedef enum logic [1:0]
    {
        OTP_RUN = 2'h0,
        OTP_WAIT = 2'h1,
        OTP_SWITCH = 2'h3
    } otp_sw_state_t;
endpackage

//--- core/otp_ripple.sv
// Free running divide counter that yields one tick per enable period for a given code.
`include "otp_defs.svh"
module otp_ripple
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Division code and tick output.
    input wire otp_pkg::otp_div_t code,
    output logic tick
);
    import otp_pkg::*;
    logic [7:0] count_reg;
    logic [7:0] mask;

    // Low code bits set; the tick marks the counter wrapping at that length.
    always_comb
    begin
        mask = 8'(({1'b0, 8'hFF} >> (4'h8 - ((code > `OTP_DIV_MAX_CODE) ? 4'h0 : code))) & 9'h0FF);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            count_reg <= 8'h00;
        else
            count_reg <= count_reg + 8'h01;
    end

    assign tick = ((count_reg & mask) == mask);
endmodule

//--- core/otp_switch.sv
// Glitch free change-over between an old and a new division rate.
module otp_switch
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Requested and active code with source ticks.
    input wire otp_pkg::otp_div_t new_code,
    input wire logic request,
    input wire logic tick_active,
    output otp_pkg::otp_div_t active_code,
    output logic switching
);
    import otp_pkg::*;
    otp_sw_state_t state_reg;
    otp_div_t pending_reg;

    // A change waits for the end of the old period, so no period is shortened. [R17]
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= OTP_RUN;
            pending_reg <= 4'h0;
        end
        else if (request)
        begin
            // A request during a pending change replaces it, so only the latest accepted write is applied.
            pending_reg <= new_code;
            state_reg <= OTP_WAIT;
        end
        else
        begin
            unique case (state_reg)
                OTP_RUN:
                    state_reg <= OTP_RUN;
                OTP_WAIT:
                    if (tick_active)
                        state_reg <= OTP_SWITCH;
                OTP_SWITCH:
                    state_reg <= OTP_RUN;
                default:
                    state_reg <= OTP_RUN;
            endcase
        end
    end

    // The new code is applied at the old period's boundary. [R18]
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            active_code <= 4'h0;
        else if (state_reg == OTP_WAIT && tick_active && !request)
            active_code <= pending_reg;
    end

    assign switching = (state_reg != OTP_RUN);
endmodule

//--- core/otp_top.sv
// Oscillator trim register and system clock prescaler with protected change sequence.
`include "otp_defs.svh"
module otp_top
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Register port.
    input wire otp_pkg::otp_byte_t reg_addr,
    input wire otp_pkg::otp_byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output otp_pkg::otp_byte_t reg_rdata,
    // Static factory inputs.
    input wire otp_pkg::otp_trim_t factory_calibration,
    input wire logic divide_by_eight_fuse,
    // Clock control outputs.
    output otp_pkg::otp_trim_t oscillator_trim,
    output logic system_clock_enable,
    output otp_pkg::otp_div_t division_active
);
    import otp_pkg::*;

    otp_div_t division_select_reg;
    logic prescale_change_enable_reg;
    logic [2:0] window_reg;
    logic tick;
    otp_div_t active_code;
    logic wr_prescale;
    logic wr_trim;
    logic div_request;
    logic div_accept;
    logic fuse_load_reg;

    function automatic logic hit(input otp_byte_t addr, input otp_byte_t target);
        hit = (addr == target);
    endfunction

    assign wr_prescale = reg_write && hit(reg_addr, `OTP_ADDR_PRESCALE);
    assign wr_trim = reg_write && hit(reg_addr, `OTP_ADDR_TRIM);

    // Division writes only count inside the window with the enable bit written zero. [R10]
    assign div_request = wr_prescale && prescale_change_enable_reg
        && !reg_wdata[`OTP_PRESCALE_CE_BIT];

    // A reserved code still closes the window but leaves the division alone. [R19]
    assign div_accept = div_request && (reg_wdata[3:0] <= `OTP_DIV_MAX_CODE);

    // Trim is loaded from the calibration byte during reset and later by software. [R3] [R20]
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            oscillator_trim <= factory_calibration;
        else if (wr_trim)
            oscillator_trim <= reg_wdata[6:0]; // [R2]
    end

    // Change enable window: set on a clean write, timed out or cleared by a division write.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prescale_change_enable_reg <= 1'b0;
            window_reg <= 3'h0;
        end
        else if (div_request)
        begin
            prescale_change_enable_reg <= 1'b0; // [R8]
            window_reg <= 3'h0;
        end
        else if (wr_prescale && reg_wdata == 8'h80 && !prescale_change_enable_reg)
        begin
            prescale_change_enable_reg <= 1'b1; // [R7]
            window_reg <= `OTP_CE_WINDOW_CYCLES - 3'h1;
        end
        else if (prescale_change_enable_reg)
        begin
            // A rewrite inside the window falls through here and changes nothing. [R9]
            if (window_reg == 3'h0)
                prescale_change_enable_reg <= 1'b0; // [R8]
            else
                window_reg <= window_reg - 3'h1;
        end
    end

    // Reset value follows the fuse; later any legal code is accepted. [R12] [R13]
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            division_select_reg <= divide_by_eight_fuse ? `OTP_DIV_RESET_FUSED
                : `OTP_DIV_RESET_PLAIN; // [R12] [R20]
        else if (div_accept)
            division_select_reg <= reg_wdata[3:0]; // [R14] [R19]
    end

    // The reset division is handed to the switch on the first edge after reset.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fuse_load_reg <= 1'b1;
        else
            fuse_load_reg <= 1'b0;
    end

    logic apply_request;
    assign apply_request = div_accept || fuse_load_reg;

    otp_ripple u_ripple
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .code(active_code),
        .tick(tick)
    );

    otp_switch u_switch
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .new_code(fuse_load_reg ? division_select_reg : reg_wdata[3:0]),
        .request(apply_request),
        .tick_active(tick),
        .active_code(active_code),
        .switching()
    );

    // One enable pulse per divided period clocks the CPU and peripherals. [R15]
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            system_clock_enable <= 1'b0;
            division_active <= 4'h0;
        end
        else
        begin
            system_clock_enable <= tick;
            division_active <= active_code;
        end
    end

    // Reserved bits read zero. [R1] [R6]
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_read && hit(reg_addr, `OTP_ADDR_PRESCALE))
            reg_rdata <= {prescale_change_enable_reg, 3'h0, division_select_reg};
        else if (reg_read && hit(reg_addr, `OTP_ADDR_TRIM))
            reg_rdata <= {1'b0, oscillator_trim};
        else
            reg_rdata <= 8'h00;
    end
endmodule

//--- dv/otp_properties.sv
// Concurrent checks on the ports of the clock control block.
module otp_checker
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Register port.
    input wire otp_pkg::otp_byte_t reg_addr,
    input wire otp_pkg::otp_byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire otp_pkg::otp_byte_t reg_rdata,
    // Factory input and clock outputs.
    input wire otp_pkg::otp_trim_t factory_calibration,
    input wire otp_pkg::otp_trim_t oscillator_trim,
    input wire logic system_clock_enable,
    input wire otp_pkg::otp_div_t division_active
);
    timeunit 1ns;
    timeprecision 100ps;
    import otp_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    trim_top_zero_a: assert property (reg_read && reg_addr == 8'h31 |=> !reg_rdata[7])
        else $error("trim bit 7 read nonzero");
    pre_rsv_zero_a: assert property (reg_read && reg_addr == 8'h26 |=> reg_rdata[6:4] == 3'h0)
        else $error("prescale bits 6:4 read nonzero");
    trim_load_a: assert property (disable iff (1'b0) reset |=> oscillator_trim == $past(factory_calibration))
        else $error("trim not loaded at reset");
    trim_hold_a: assert property (!(reg_write && reg_addr == 8'h31) |=> $stable(oscillator_trim))
        else $error("trim changed without write");
    div_legal_a: assert property (division_active <= 4'h8)
        else $error("reserved division active");
    fast_pulse_a: assert property (system_clock_enable ##1 system_clock_enable |->
        division_active == 4'h0 || $past(division_active) == 4'h0) else $error("short period");
    ce_write_clr_a: assert property (reg_write && reg_addr == 8'h26 && !reg_wdata[7]
        ##1 !reg_write ##[0:1] reg_read && reg_addr == 8'h26 |=> !reg_rdata[7])
        else $error("enable not cleared");
    ce_timeout_a: assert property (reg_write && reg_addr == 8'h26 && reg_wdata == 8'h80
        ##1 !reg_write [*5] ##1 reg_read && reg_addr == 8'h26 |=> !reg_rdata[7])
        else $error("enable window not closed");
    c_prot: cover property (reg_write && reg_addr == 8'h26 && reg_wdata == 8'h80);
    c_switch: cover property ($changed(division_active));
    c_trim: cover property (reg_write && reg_addr == 8'h31);
endmodule
bind otp_top otp_checker u_otp_checker (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .factory_calibration(factory_calibration), .oscillator_trim(oscillator_trim),
    .system_clock_enable(system_clock_enable), .division_active(division_active));

//--- dv/test_osc_trim_and_clock_prescaler.sv
// Self-checking bench for the oscillator trim register and clock prescaler.
module test_osc_trim_and_clock_prescaler;
    timeunit 1ns;
    timeprecision 100ps;
    import otp_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    otp_byte_t reg_addr = 8'h00;
    otp_byte_t reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    otp_byte_t reg_rdata;
    otp_trim_t factory_calibration = 7'h55;
    logic divide_by_eight_fuse = 1'b1;
    otp_trim_t oscillator_trim;
    logic system_clock_enable;
    otp_div_t division_active;
    otp_div_t prev;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    otp_top u_otp_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .factory_calibration(factory_calibration),
        .divide_by_eight_fuse(divide_by_eight_fuse), .oscillator_trim(oscillator_trim),
        .system_clock_enable(system_clock_enable), .division_active(division_active));
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input otp_byte_t a, input otp_byte_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rc(input otp_byte_t a, input otp_byte_t exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 check(16'(reg_rdata), 16'(exp));
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Measures the spacing of enable pulses once the new code is active.
    task automatic gap(input otp_div_t code);
        int n;
        n = 0;
        while ((division_active !== code || system_clock_enable !== 1'b1) && n < 1000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        while (system_clock_enable !== 1'b1 && n < 300);
        check(16'(n), 16'h0001 << code);
        check(16'(division_active), 16'(code));
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        idle(2);
        rc(8'h31, 8'h55);
        rc(8'h26, 8'h03);
        check(16'(division_active), 16'h0003);
        rc(8'h40, 8'h00);
        wr(8'h31, 8'hF5);
        rc(8'h31, 8'h75);
        check(16'(oscillator_trim), 16'h0075);
        wr(8'h26, 8'h81);
        wr(8'h26, 8'h01);
        rc(8'h26, 8'h03);
        prev = 4'h3;
        for (int c = 0; c <= 8; c++)
        begin
            wr(8'h26, 8'h80);
            rc(8'h26, {4'h8, prev});
            wr(8'h26, 8'(c));
            rc(8'h26, 8'(c));
            gap(4'(c));
            prev = 4'(c);
        end
        wr(8'h26, 8'h80);
        wr(8'h26, 8'h09);
        rc(8'h26, 8'h08);
        wr(8'h26, 8'h80);
        idle(3);
        wr(8'h26, 8'h02);
        rc(8'h26, 8'h08);
        wr(8'h26, 8'h80);
        idle(4);
        rc(8'h26, 8'h08);
        wr(8'h26, 8'h80);
        wr(8'h26, 8'h80);
        rc(8'h26, 8'h88);
        wr(8'h26, 8'h01);
        rc(8'h26, 8'h08);
        @(posedge ref_clk);
        reset <= 1'b1;
        factory_calibration <= 7'h12;
        divide_by_eight_fuse <= 1'b0;
        idle(5);
        reset <= 1'b0;
        factory_calibration <= 7'h2A;
        divide_by_eight_fuse <= 1'b1;
        idle(2);
        rc(8'h31, 8'h12);
        rc(8'h26, 8'h00);
        check(16'(division_active), 16'h0000);
        end_of_test();
    end
endmodule
